// ===== hdl/pst_pkg.sv
// Package with the shared constants and carrier types of the pixel serializer.
package pst_pkg;

  // Width of one colour channel.
  localparam int COLOR_W = 8;
  // Width of the whole parallel word.
  localparam int WORD_W = 28;
  // Number of serial data lanes.
  localparam int LANES = 4;
  // Number of bit slots per pixel period.
  localparam int SLOTS = 7;
  // Core clock period in picoseconds.
  localparam int CLK_PERIOD_PS = 8000;
  // Longest allowed power-down entry time, in ns.
  localparam int PWRDN_MAX_NS = 100;
  // Power-down entry in cycles, rounded down and never below one.
  localparam int PWRDN_CYC = (PWRDN_MAX_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 :
                             (PWRDN_MAX_NS * 1000 / CLK_PERIOD_PS);
  // Longest allowed lock time, in ms.
  localparam int LOCK_MAX_MS = 10;
  // Lock time in cycles, rounded down.
  localparam int LOCK_CYC = LOCK_MAX_MS * 1000 * 1000 / (CLK_PERIOD_PS / 1000);
  // Forwarded clock pattern over the seven slots: high for slots 0 to 3.
  localparam logic [6:0] CLK_PATTERN = 7'h0F;
  // Reset value of the slot counter.
  localparam logic [2:0] SLOT_RST = 3'h0;

  // One parallel pixel word as the controller presents it.
  typedef struct packed {
    logic [3:0] ctrl;
    logic [COLOR_W-1:0] blue;
    logic [COLOR_W-1:0] green;
    logic [COLOR_W-1:0] red;
  } pst_word_t;

  // Transmit sequencer states.
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b001,
    ST_LOCK = 3'b010,
    ST_RUN = 3'b100
  } pst_state_t;

endpackage : pst_pkg

// ===== hdl/pst_buf2.sv
// Two-entry valid/ready buffer that carries pixel words.
`timescale 1ns/10ps
module pst_buf2 #(
  parameter int WIDTH = 28
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // Storage for the two entries.
  logic [WIDTH-1:0] mem_r [2];
  logic [WIDTH-1:0] mem_nxt [2];
  // Read and write pointers, one bit each.
  logic rd_r, rd_nxt, wr_r, wr_nxt;
  // Occupancy, zero to two.
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Handshakes are combinational; full refuses the filler honestly.
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next values of pointers, count and storage.
  always_comb begin
    mem_nxt = mem_r;
    rd_nxt = rd_r;
    wr_nxt = wr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = ~wr_r;
    end
    if (pop) begin
      rd_nxt = ~rd_r;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  // Registers only; storage is not reset since count guards it.
  always_ff @(posedge core_clk) begin
    mem_r <= mem_nxt;
    if (!rst_n) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule : pst_buf2

// ===== hdl/pst_serializer_tx.sv
// Pixel word serializer: four data lanes plus a forwarded clock lane.
//
// How it works
// - Take one 28-bit word: RGB plus controls.
// - Sample word on falling shift clock edge.
// - Seven bit slots per pixel period.
// - Drive four data lanes and forwarded clock.
// - Sleep input low tri-states all lane outputs.
// - Enter sleep within 100 ns.
// - Hold outputs off until lock time passes.
`timescale 1ns/10ps
module pst_serializer_tx #(
  // Lock wait in core cycles; shorten for simulation.
  parameter int LOCK_CYCLES = pst_pkg::LOCK_CYC
) (
  // Clock and reset; core_clk runs at the bit slot rate.
  input wire logic core_clk,
  input wire logic rst_n,
  // Parallel side from the display controller.
  input wire logic pixel_shift_clock_in,
  input wire pst_pkg::pst_word_t parallel_pixel_in,
  // Sleep request, active low.
  input wire logic sleep_request_n,
  // Serial data lanes.
  output logic [pst_pkg::LANES-1:0] serial_lane_pos,
  output logic [pst_pkg::LANES-1:0] serial_lane_neg,
  output logic [pst_pkg::LANES-1:0] serial_lane_oe,
  // Forwarded clock lane.
  output logic forwarded_clock_pos,
  output logic forwarded_clock_neg,
  output logic forwarded_clock_oe,
  // Sequencer status and overflow notice.
  output logic link_locked,
  output logic word_dropped
);

  // A lock wait of zero cycles would stay in the lock state until the 32-bit count reaches all ones; refuse it while elaborating.
  if (LOCK_CYCLES < 1) begin : g_bad_lock
    $error("LOCK_CYCLES must be at least one");
  end

  // Sequencer state and lock counter.
  pst_pkg::pst_state_t st_r, st_nxt;
  logic [31:0] lock_cnt_r, lock_cnt_nxt;
  // Previous shift clock level, for edge detection.
  logic shift_d_r, shift_d_nxt;
  // Slot position within the pixel period.
  logic [2:0] slot_r, slot_nxt;
  // Word being shifted out.
  logic [pst_pkg::WORD_W-1:0] shreg_r, shreg_nxt;
  // Registered lane outputs.
  logic [pst_pkg::LANES-1:0] lane_r, lane_nxt;
  logic fclk_r, fclk_nxt, oe_r, oe_nxt, drop_r, drop_nxt;
  // Buffer handshakes.
  logic fall, buf_in_ready, buf_out_valid, take;
  logic [pst_pkg::WORD_W-1:0] buf_out_data;

  // Map of word bit to lane and slot; one fixed layout.
  function automatic logic [pst_pkg::LANES-1:0] lane_bits(
    input logic [pst_pkg::WORD_W-1:0] w, input logic [2:0] s);
    logic [pst_pkg::LANES-1:0] r;
    r = '0;
    for (int l = 0; l < pst_pkg::LANES; l++) begin
      r[l] = w[l * pst_pkg::SLOTS + int'(s)];
    end
    return r;
  endfunction : lane_bits

  // A falling shift clock edge strobes the word in while running.
  assign fall = shift_d_r && !pixel_shift_clock_in;
  // The word leaves the buffer at the start of each slot 0.
  assign take = (st_r == pst_pkg::ST_RUN) && (slot_r == pst_pkg::SLOT_RST) && buf_out_valid;

  // Buffer between the strobe and the shifter, absorbing a late slot 0.
  pst_buf2 #(.WIDTH(pst_pkg::WORD_W)) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(fall && st_r == pst_pkg::ST_RUN),
    .in_ready(buf_in_ready),
    .in_data(parallel_pixel_in),
    .out_valid(buf_out_valid),
    .out_ready(take),
    .out_data(buf_out_data)
  );

  // Sequencer: sleep, lock wait, then transmit.
  always_comb begin
    st_nxt = st_r;
    lock_cnt_nxt = lock_cnt_r;
    unique case (st_r)
      pst_pkg::ST_SLEEP: begin
        lock_cnt_nxt = '0;
        if (sleep_request_n) begin
          st_nxt = pst_pkg::ST_LOCK;
        end
      end
      pst_pkg::ST_LOCK: begin
        lock_cnt_nxt = lock_cnt_r + 32'h1;
        if (lock_cnt_r == 32'(LOCK_CYCLES - 1)) begin
          st_nxt = pst_pkg::ST_RUN;
        end
      end
      pst_pkg::ST_RUN: begin
        lock_cnt_nxt = lock_cnt_r;
      end
      default: begin
        st_nxt = pst_pkg::ST_SLEEP;
      end
    endcase
    // Sleep overrides everything on the next edge.
    if (!sleep_request_n) begin
      st_nxt = pst_pkg::ST_SLEEP;
    end
  end

  // Shifter and lane drivers.
  always_comb begin
    shift_d_nxt = pixel_shift_clock_in;
    slot_nxt = slot_r;
    shreg_nxt = shreg_r;
    lane_nxt = lane_r;
    fclk_nxt = fclk_r;
    oe_nxt = 1'b0;
    drop_nxt = fall && (st_r == pst_pkg::ST_RUN) && !buf_in_ready;
    if (st_r == pst_pkg::ST_RUN && sleep_request_n) begin
      oe_nxt = 1'b1;
      slot_nxt = (slot_r == 3'h6) ? pst_pkg::SLOT_RST : slot_r + 3'h1;
      if (take) begin
        shreg_nxt = buf_out_data;
      end
      lane_nxt = lane_bits(take ? buf_out_data : shreg_r, slot_r);
      fclk_nxt = pst_pkg::CLK_PATTERN[slot_r];
    end else begin
      slot_nxt = pst_pkg::SLOT_RST;
      lane_nxt = '0;
      fclk_nxt = 1'b0;
    end
  end

  // Register stage for all state.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= pst_pkg::ST_SLEEP;
      lock_cnt_r <= '0;
      shift_d_r <= 1'b0;
      slot_r <= pst_pkg::SLOT_RST;
      shreg_r <= '0;
      lane_r <= '0;
      fclk_r <= 1'b0;
      oe_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      shift_d_r <= shift_d_nxt;
      slot_r <= slot_nxt;
      shreg_r <= shreg_nxt;
      lane_r <= lane_nxt;
      fclk_r <= fclk_nxt;
      oe_r <= oe_nxt;
      drop_r <= drop_nxt;
    end
  end

  // Outputs; negative legs are the complement.
  assign serial_lane_pos = lane_r;
  assign serial_lane_neg = ~lane_r;
  assign serial_lane_oe = {pst_pkg::LANES{oe_r}};
  assign forwarded_clock_pos = fclk_r;
  assign forwarded_clock_neg = ~fclk_r;
  assign forwarded_clock_oe = oe_r;
  assign link_locked = (st_r == pst_pkg::ST_RUN);
  assign word_dropped = drop_r;

  // Outputs go off within the power-down bound.
  AST_SLEEP_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sleep_request_n |-> ##[1:2] !forwarded_clock_oe)
    else $error("outputs still enabled after sleep");
  // Outputs stay off while asleep.
  AST_SLEEP_HIZ: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sleep_request_n ##1 !sleep_request_n |-> serial_lane_oe == '0)
    else $error("lanes driven during sleep");
  // No drive before lock.
  AST_NO_DRIVE_UNLOCKED: assert property (@(posedge core_clk) disable iff (!rst_n)
    forwarded_clock_oe |-> $past(st_r) == pst_pkg::ST_RUN)
    else $error("driven before lock");
  // Slot counter wraps after slot six.
  AST_SLOT_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
    slot_r == 3'h6 && st_r == pst_pkg::ST_RUN && sleep_request_n |=> slot_r == 3'h0)
    else $error("slot did not wrap");
  // Slot never exceeds six.
  AST_SLOT_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    slot_r <= 3'h6)
    else $error("slot out of range");
  // Forwarded clock follows the pattern of the previous slot.
  AST_FCLK_PATTERN: assert property (@(posedge core_clk) disable iff (!rst_n)
    forwarded_clock_oe |-> forwarded_clock_pos == pst_pkg::CLK_PATTERN[$past(slot_r)])
    else $error("forwarded clock pattern wrong");
  // Differential legs stay complementary.
  AST_DIFF_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    serial_lane_neg == ~serial_lane_pos)
    else $error("lane legs not complementary");
  // A loaded word appears on lane bits of slot 0.
  AST_MAP_SLOT0: assert property (@(posedge core_clk) disable iff (!rst_n)
    take && sleep_request_n |=> serial_lane_pos == lane_bits($past(buf_out_data), 3'h0))
    else $error("slot zero mapping wrong");
  // A falling strobe in run with room is buffered, not dropped.
  AST_STROBE_TAKEN: assert property (@(posedge core_clk) disable iff (!rst_n)
    fall && st_r == pst_pkg::ST_RUN && buf_in_ready |=> !word_dropped && buf_out_valid)
    else $error("word dropped with room");

endmodule : pst_serializer_tx

// ===== testbench/pst_rx_model.sv
// Link receiver model that rebuilds pixel words from the serial lanes.
`timescale 1ns/10ps
module pst_rx_model (
  // Clock and the bench's cycle count.
  core_clk,
  cyc,
  // Lanes from the transmitter.
  lane_pos,
  lane_neg,
  lane_oe,
  fclk_pos,
  fclk_neg,
  fclk_oe,
  // Rebuilt word and fault count.
  rx_valid,
  rx_word,
  rx_start,
  bad_cnt
);
  input wire logic core_clk;
  input int cyc;
  input wire logic [3:0] lane_pos;
  input wire logic [3:0] lane_neg;
  input wire logic [3:0] lane_oe;
  input wire logic fclk_pos;
  input wire logic fclk_neg;
  input wire logic fclk_oe;
  output logic rx_valid = 1'b0;
  output pst_pkg::pst_word_t rx_word = '0;
  output int rx_start = 0;
  output int bad_cnt = 0;
  int slot = 7; // Seven means no frame in progress.
  logic fclk_q = 1'b0; // Forwarded clock one slot ago.
  logic [27:0] acc; // Word being rebuilt.
  // Sampling mid-cycle keeps clear of the edge that launches the lanes.
  always @(negedge core_clk) begin
    rx_valid = 1'b0;
    if (lane_oe !== 4'hF || fclk_oe !== 1'b1) begin
      slot = 7;
      fclk_q = 1'b0;
    end else begin
      if (lane_neg !== ~lane_pos || fclk_neg !== ~fclk_pos) bad_cnt++;
      if (fclk_pos === 1'b1 && fclk_q === 1'b0) begin
        slot = 0;
        rx_start = cyc;
      end
      if (slot < 7) begin
        if (fclk_pos !== (slot < 4)) bad_cnt++;
        for (int l = 0; l < 4; l++) acc[7*l+slot] = lane_pos[l];
        slot++;
        if (slot == 7) begin
          rx_word = acc;
          rx_valid = 1'b1;
        end
      end
      fclk_q = fclk_pos;
    end
  end
endmodule : pst_rx_model

// ===== testbench/tb_top.sv
// Testbench that streams pixel words through the serializer and checks the lanes.
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0; // Slot clock, 8 ns.
  logic rst_n = 1'b0; // Reset, active low.
  logic shift_clk = 1'b0; // Pixel strobe.
  pst_pkg::pst_word_t pix_word = '0; // Parallel word.
  logic sleep_n = 1'b1; // Sleep request, active low.
  logic [3:0] lane_pos;
  logic [3:0] lane_neg;
  logic [3:0] lane_oe;
  logic fclk_pos;
  logic fclk_neg;
  logic fclk_oe;
  logic locked;
  logic dropped;
  logic rx_valid;
  pst_pkg::pst_word_t rx_word;
  int rx_start;
  int bad_cnt;
  int cyc = 0; // Rising edges seen so far.
  int error_cnt = 0;
  int num_checks = 0;
  int drops = 0;
  logic [31:0] seed = 32'h00001F29; // Random state.
  logic [27:0] exp_q[$]; // Words the receiver should see.
  int exp_t[$]; // Edge at which each word was captured.

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) cyc++;

  // Lock is cut to four cycles so a wake-up stays short.
  pst_serializer_tx #(.LOCK_CYCLES(4)) pst_serializer_tx_inst (
    .core_clk(core_clk), .rst_n(rst_n), .pixel_shift_clock_in(shift_clk),
    .parallel_pixel_in(pix_word), .sleep_request_n(sleep_n),
    .serial_lane_pos(lane_pos), .serial_lane_neg(lane_neg), .serial_lane_oe(lane_oe),
    .forwarded_clock_pos(fclk_pos), .forwarded_clock_neg(fclk_neg),
    .forwarded_clock_oe(fclk_oe), .link_locked(locked), .word_dropped(dropped));

  pst_rx_model pst_rx_model_inst (
    .core_clk(core_clk), .cyc(cyc), .lane_pos(lane_pos), .lane_neg(lane_neg),
    .lane_oe(lane_oe), .fclk_pos(fclk_pos), .fclk_neg(fclk_neg), .fclk_oe(fclk_oe),
    .rx_valid(rx_valid), .rx_word(rx_word), .rx_start(rx_start), .bad_cnt(bad_cnt));

  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xorshift

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One random word, strobed over two cycles, then idle for gap minus two cycles; keep says it must arrive.
  task automatic strobe(input int gap, input bit keep);
    seed = xorshift(seed);
    @(negedge core_clk);
    pix_word = seed[27:0];
    shift_clk = 1'b1;
    @(negedge core_clk);
    shift_clk = 1'b0;
    if (keep) begin
      exp_q.push_back(pix_word);
      exp_t.push_back(cyc + 1);
    end
    repeat (gap - 2) @(negedge core_clk);
  endtask : strobe

  task automatic wait_lock;
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    // The lanes switch on one edge after the sequencer reaches run.
    @(negedge core_clk);
    check({locked, lane_oe, fclk_oe, n >= 3 && n <= 10}, 7'h7F);
  endtask : wait_lock

  task automatic drain(input string name);
    int n;
    n = 0;
    while (exp_q.size() > 0 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    check(exp_q.size(), 0);
    $display("test %s done", name);
  endtask : drain

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // A full buffer refuses the word strobed at the edge that raised the pulse.
  always @(negedge core_clk) begin
    if (dropped === 1'b1) begin
      int hit;
      hit = 0;
      drops++;
      for (int i = 0; i < exp_t.size(); i++) begin
        if (exp_t[i] == cyc) begin
          exp_q.delete(i);
          exp_t.delete(i);
          hit = 1;
          break;
        end
      end
      // A drop pulse with no strobe at that edge is a fault of its own.
      check(hit, 1);
    end
  end

  // The head word leaves the buffer one edge after capture at the earliest.
  // Frames that began before that are idle filler.
  always @(posedge core_clk) begin
    if (rx_valid === 1'b1 && exp_q.size() > 0 && rx_start >= exp_t[0] + 1) begin
      check(rx_word, exp_q.pop_front());
      void'(exp_t.pop_front());
    end
  end

  initial begin
    repeat (10) @(negedge core_clk);
    check({lane_oe, fclk_oe, locked}, 6'h00);
    rst_n = 1'b1;
    wait_lock();
    repeat (20) strobe(7, 1'b1);
    drain("stream");
    // One word per pixel period never overfills the buffer.
    check(drops, 0);
    repeat (6) strobe(2, 1'b1);
    drain("burst");
    check(drops > 0, 1'b1);
    sleep_n = 1'b0;
    repeat (2) @(negedge core_clk);
    check({lane_oe, fclk_oe, locked}, 6'h00);
    strobe(7, 1'b0);
    sleep_n = 1'b1;
    wait_lock();
    repeat (4) strobe(7, 1'b1);
    drain("sleep");
    check(bad_cnt, 0);
    final_report();
  end

  // The tests need well under 1000 cycles; 5000 leaves ample margin.
  initial begin
    #40000;
    error_cnt++;
    final_report();
  end
endmodule : tb_top
